/* hw/clk_switch_pkg.sv */
/*
  Constants, register map and encodings for the clock switch and oscillator status block.
  Assumes an AXI4-Lite master with 32-bit data and byte addresses.
*/
package clk_switch_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned ADDR_W          = 8;
  localparam int unsigned NUM_OSC         = 7;
  localparam int unsigned STARTUP_PERIODS = 1024;
  localparam int unsigned STARTUP_CNT_W   = 11;

  // Register byte offsets.
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_CURRENT  = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_ENABLE   = 8'h0C;
  localparam logic [7:0] OFS_HF_FREQ  = 8'h10;
  localparam logic [7:0] OFS_FLAGS    = 8'h14;

  // Field positions in the control register.
  localparam int unsigned CTL_DIV_LSB = 0;
  localparam int unsigned CTL_SRC_LSB = 4;
  localparam int unsigned CTL_HOLD    = 8;
  localparam int unsigned CTL_IRQ_EN  = 9;

  // Field positions in the flags register.
  localparam int unsigned FLG_DONE     = 0;
  localparam int unsigned FLG_NEW_RDY  = 1;
  localparam int unsigned FLG_COMPLETE = 2;

  // Bit positions of oscillators in the status and enable words.
  localparam int unsigned OSC_EXT  = 0;
  localparam int unsigned OSC_HF   = 1;
  localparam int unsigned OSC_MID  = 2;
  localparam int unsigned OSC_LOW  = 3;
  localparam int unsigned OSC_SEC  = 4;
  localparam int unsigned OSC_ADC  = 5;
  localparam int unsigned OSC_FIX  = 6;
  localparam int unsigned STS_PLL  = 7;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [3:0] DIV_MAX      = 4'h9;
  localparam logic [3:0] DIV_RESET    = 4'h0;
  localparam logic [3:0] HF_FREQ_RST  = 4'h0;

  typedef enum logic [2:0] {
    SRC_RSVD0   = 3'b000,
    SRC_RSVD1   = 3'b001,
    SRC_EXT_PLL = 3'b010,
    SRC_RSVD3   = 3'b011,
    SRC_SEC     = 3'b100,
    SRC_LOW     = 3'b101,
    SRC_HF      = 3'b110,
    SRC_EXT     = 3'b111
  } src_t;

  localparam src_t SRC_RESET = SRC_HF;

  // Legal source code check.
  function automatic logic src_legal(input logic [2:0] s);
    return (s == SRC_EXT) || (s == SRC_HF) || (s == SRC_LOW) ||
           (s == SRC_SEC) || (s == SRC_EXT_PLL);
  endfunction

endpackage

/* hw/startup_count_timer.sv */
/*
  Start-up timer for one external oscillator.
  Assumes osc_clk_i is an oscillator level from outside; it is synchronised here.
*/
`timescale 1ns/10ps
module startup_count_timer #(
  parameter int unsigned PERIODS = clk_switch_pkg::STARTUP_PERIODS
) (
  input  wire logic clk_i,      // System clock.
  input  wire logic rstn_i,     // Asynchronous reset, active low.
  input  wire logic enable_i,   // Oscillator requested on.
  input  wire logic osc_clk_i,  // Oscillator output level.
  output logic      ready_o     // Oscillator stable.
);
  import clk_switch_pkg::*;

  logic                     sync1_reg, sync2_reg, sync3_reg;
  logic [STARTUP_CNT_W-1:0] count_reg, count_next;
  logic                     ready_reg, ready_next;

  // Count rising edges of the synchronised oscillator; restart when disabled.
  always_comb begin
    count_next = count_reg;
    ready_next = ready_reg;
    if (!enable_i) begin
      count_next = '0;
      ready_next = 1'b0;
    end else if (sync2_reg && !sync3_reg && !ready_reg) begin
      count_next = count_reg + 1'b1;
      if (count_reg == STARTUP_CNT_W'(PERIODS - 1)) begin
        ready_next = 1'b1;
      end
    end
  end

  // State registers.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      count_reg <= '0;
      ready_reg <= 1'b0;
    end else begin
      sync1_reg <= osc_clk_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      count_reg <= count_next;
      ready_reg <= ready_next;
    end
  end

  assign ready_o = ready_reg;
endmodule // startup_count_timer

/* hw/divider_select.sv */
/*
  Registered post-scaler clock enable generator for the system clock divider.
  Assumes the divider code has already been checked legal.
*/
`timescale 1ns/10ps
module divider_select (
  input  wire logic       clk_i,     // System clock.
  input  wire logic       rstn_i,    // Asynchronous reset, active low.
  input  wire logic [3:0] div_i,     // Divide by two to the power of this code.
  output logic            tick_o     // One-cycle pulse every divided period.
);
  import clk_switch_pkg::*;

  logic [9:0] count_reg, count_next;
  logic       tick_reg, tick_next;

  // Terminal count for a divider code.
  function automatic logic [9:0] term(input logic [3:0] d);
    return 10'((11'h001 << d) - 11'h001);
  endfunction

  // Count up to two to the power of the code, less one, then pulse.
  always_comb begin
    tick_next  = 1'b0;
    count_next = count_reg + 10'h001;
    if (count_reg >= term(div_i)) begin
      count_next = 10'h000;
      tick_next  = 1'b1;
    end
  end

  // State registers.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_reg <= 10'h000;
      tick_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg  <= tick_next;
    end
  end

  assign tick_o = tick_reg;
endmodule // divider_select

/* hw/system_clock_switch_status.sv */
/*
  System clock switch control with oscillator ready status and manual enables.
  Assumes an AXI4-Lite master, analog ready and level inputs from the oscillators,
  and sleep and doze levels from the power controller.
*/
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
module system_clock_switch_status
  import clk_switch_pkg::*;
#(
  parameter int unsigned STARTUP = clk_switch_pkg::STARTUP_PERIODS
) (
  input  wire logic                        clk_i,            // System clock.
  input  wire logic                        rstn_i,           // Reset, active low.
  input  wire logic [clk_switch_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address.
  input  wire logic                        s_axi_awvalid,    // Write address valid.
  output logic                             s_axi_awready,    // Write address ready.
  input  wire logic [31:0]                 s_axi_wdata,      // Write data.
  input  wire logic [3:0]                  s_axi_wstrb,      // Write strobes.
  input  wire logic                        s_axi_wvalid,     // Write data valid.
  output logic                             s_axi_wready,     // Write data ready.
  output logic [1:0]                       s_axi_bresp,      // Write response.
  output logic                             s_axi_bvalid,     // Write response valid.
  input  wire logic                        s_axi_bready,     // Write response ready.
  input  wire logic [clk_switch_pkg::ADDR_W-1:0] s_axi_araddr, // Read address.
  input  wire logic                        s_axi_arvalid,    // Read address valid.
  output logic                             s_axi_arready,    // Read address ready.
  output logic [31:0]                      s_axi_rdata,      // Read data.
  output logic [1:0]                       s_axi_rresp,      // Read response.
  output logic                             s_axi_rvalid,     // Read data valid.
  input  wire logic                        s_axi_rready,     // Read data ready.
  input  wire logic                        switch_permit_config_i, // Switch permit strap.
  input  wire logic                        sleep_i,          // Sleep mode level.
  input  wire logic                        doze_i,           // Doze mode level.
  input  wire logic                        ext_osc_clk_i,    // External oscillator level.
  input  wire logic                        sec_osc_clk_i,    // Secondary oscillator level.
  input  wire logic [4:0]                  int_accurate_i,   // HF, mid, low, ADC, fixed.
  input  wire logic                        multiplier_lock_i, // PLL lock from analog.
  output logic [6:0]                       osc_run_o,        // Oscillator run requests.
  output logic                             hf_output_hold_o, // Freeze HF output.
  output logic [3:0]                       hf_frequency_select_o, // HF frequency code.
  output logic [2:0]                       current_source_o, // Active source.
  output logic [3:0]                       current_divider_o, // Active divider.
  output logic                             sys_tick_o,       // Divided clock enable.
  output logic                             irq_o             // Switch done interrupt.
);

  // Synchronisers for asynchronous analog levels, first stage read only by second.
  logic [4:0] acc_s1_reg, acc_s2_reg;
  logic       pll_s1_reg, pll_s2_reg;
  logic       cfg_s1_reg, cfg_s2_reg;
  logic       ext_ready, sec_ready;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_s1_reg <= 5'h00;
      acc_s2_reg <= 5'h00;
      pll_s1_reg <= 1'b0;
      pll_s2_reg <= 1'b0;
      cfg_s1_reg <= 1'b0;
      cfg_s2_reg <= 1'b0;
    end else begin
      acc_s1_reg <= int_accurate_i;
      acc_s2_reg <= acc_s1_reg;
      pll_s1_reg <= multiplier_lock_i;
      pll_s2_reg <= pll_s1_reg;
      cfg_s1_reg <= switch_permit_config_i;
      cfg_s2_reg <= cfg_s1_reg;
    end
  end

  // Software visible state.
  logic [2:0] req_src_reg, req_src_next;
  logic [3:0] req_div_reg, req_div_next;
  logic [2:0] cur_src_reg, cur_src_next;
  logic [3:0] cur_div_reg, cur_div_next;
  logic       hold_reg, hold_next;
  logic       irq_en_reg, irq_en_next;
  logic       done_reg, done_next;
  logic       new_rdy_reg, new_rdy_next;
  logic       complete_reg, complete_next;
  logic       pending_reg, pending_next;
  logic [5:0] man_en_reg, man_en_next;
  logic [3:0] hf_freq_reg, hf_freq_next;
  logic       hf_relock_reg, hf_relock_next;
  logic [6:0] run_reg, run_next;
  logic       irq_reg, irq_next;

  // AXI slave state.
  logic                awv_reg, awv_next;
  logic                wv_reg, wv_next;
  logic [ADDR_W-1:0]   awa_reg, awa_next;
  logic [31:0]         wd_reg, wd_next;
  logic [3:0]          ws_reg, ws_next;
  logic                bv_reg, bv_next;
  logic [1:0]          br_reg, br_next;
  logic                rv_reg, rv_next;
  logic [31:0]         rd_reg, rd_next;
  logic [1:0]          rr_reg, rr_next;

  // Status word built from ready flags.
  logic [7:0] status_w;
  logic       sel_ready;
  logic       wr_go;

  // Ready flag of the oscillator behind a source code.
  function automatic logic src_ready(input logic [2:0] s, input logic [7:0] st);
    unique case (s)
      SRC_EXT:     return st[OSC_EXT];
      SRC_HF:      return st[OSC_HF];
      SRC_LOW:     return st[OSC_LOW];
      SRC_SEC:     return st[OSC_SEC];
      SRC_EXT_PLL: return st[OSC_EXT] && st[STS_PLL];
      default:     return 1'b0;
    endcase
  endfunction

  // Run request mask of a source code.
  function automatic logic [6:0] src_run(input logic [2:0] s);
    unique case (s)
      SRC_EXT, SRC_EXT_PLL: return 7'(1) << OSC_EXT;
      SRC_HF:               return 7'(1) << OSC_HF;
      SRC_LOW:              return 7'(1) << OSC_LOW;
      SRC_SEC:              return 7'(1) << OSC_SEC;
      default:              return 7'h00;
    endcase
  endfunction

  // Start-up timers on the external and secondary oscillators.
  startup_count_timer #(.PERIODS(STARTUP)) u_ext_timer (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .enable_i  (run_reg[OSC_EXT]),
    .osc_clk_i (ext_osc_clk_i),
    .ready_o   (ext_ready)
  );

  startup_count_timer #(.PERIODS(STARTUP)) u_sec_timer (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .enable_i  (run_reg[OSC_SEC]),
    .osc_clk_i (sec_osc_clk_i),
    .ready_o   (sec_ready)
  );

  divider_select u_div (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .div_i  (cur_div_reg),
    .tick_o (sys_tick_o)
  );

  // Ready flags; internal ones follow accuracy, HF also blocked while relocking.
  always_comb begin
    status_w          = 8'h00;
    status_w[OSC_EXT] = ext_ready;
    status_w[OSC_SEC] = sec_ready;
    status_w[OSC_HF]  = acc_s2_reg[0] && run_reg[OSC_HF] && !hf_relock_reg;
    status_w[OSC_MID] = acc_s2_reg[1] && run_reg[OSC_MID];
    status_w[OSC_LOW] = acc_s2_reg[2] && run_reg[OSC_LOW];
    status_w[OSC_ADC] = acc_s2_reg[3] && run_reg[OSC_ADC];
    status_w[OSC_FIX] = acc_s2_reg[4] && run_reg[OSC_HF];
    status_w[STS_PLL] = pll_s2_reg && run_reg[OSC_EXT] && (req_src_reg == SRC_EXT_PLL);
    sel_ready         = src_ready(req_src_reg, status_w);
  end

  // Bus writes and the switch sequencer.
  always_comb begin
    logic [31:0] wv;
    wv             = wd_reg;
    awv_next       = awv_reg;
    wv_next        = wv_reg;
    awa_next       = awa_reg;
    wd_next        = wd_reg;
    ws_next        = ws_reg;
    bv_next        = bv_reg;
    br_next        = br_reg;
    req_src_next   = req_src_reg;
    req_div_next   = req_div_reg;
    cur_src_next   = cur_src_reg;
    cur_div_next   = cur_div_reg;
    hold_next      = hold_reg;
    irq_en_next    = irq_en_reg;
    done_next      = done_reg;
    new_rdy_next   = new_rdy_reg;
    complete_next  = complete_reg;
    pending_next   = pending_reg;
    man_en_next    = man_en_reg;
    hf_freq_next   = hf_freq_reg;
    hf_relock_next = hf_relock_reg && !acc_s2_reg[0] ? 1'b1 : 1'b0;
    if (s_axi_awvalid && !awv_reg) begin
      awv_next = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wv_reg) begin
      wv_next = 1'b1;
      wd_next = s_axi_wdata;
      ws_next = s_axi_wstrb;
    end
    if (bv_reg && s_axi_bready) begin
      bv_next = 1'b0;
    end
    wr_go = awv_reg && wv_reg && !bv_reg;
    // Sequencer: sleep blocks, hold suspends, otherwise switch on ready.
    if (pending_reg && sel_ready && !new_rdy_reg) begin
      new_rdy_next = 1'b1;
    end
    if (pending_reg && new_rdy_reg && !hold_reg && !sleep_i) begin
      cur_src_next  = req_src_reg;
      cur_div_next  = req_div_reg;
      complete_next = 1'b1;
      new_rdy_next  = 1'b0;
      pending_next  = 1'b0;
      done_next     = 1'b1;
    end
    if (sleep_i && hold_reg && pending_reg) begin
      new_rdy_next = 1'b0;
    end
    if (wr_go) begin
      bv_next  = 1'b1;
      br_next  = RESP_OKAY;
      awv_next = 1'b0;
      wv_next  = 1'b0;
      unique case (awa_reg)
        OFS_CONTROL: begin
          if (ws_reg[0] && cfg_s2_reg) begin
            if (src_legal(wv[CTL_SRC_LSB +: 3]) && wv[CTL_DIV_LSB +: 4] <= DIV_MAX) begin
              req_src_next  = wv[CTL_SRC_LSB +: 3];
              req_div_next  = wv[CTL_DIV_LSB +: 4];
              pending_next  = (wv[CTL_SRC_LSB +: 3] != cur_src_reg) ||
                              (wv[CTL_DIV_LSB +: 4] != cur_div_reg);
              complete_next = 1'b0;
              new_rdy_next  = 1'b0;
            end
          end
          if (ws_reg[1]) begin
            hold_next   = wv[CTL_HOLD];
            irq_en_next = wv[CTL_IRQ_EN];
          end
        end
        OFS_ENABLE:  if (ws_reg[0]) man_en_next = wv[5:0];
        OFS_HF_FREQ: if (ws_reg[0]) begin
          hf_freq_next   = wv[3:0];
          hf_relock_next = 1'b1;
        end
        // Writing one clears the done flag; a same-cycle set wins.
        OFS_FLAGS:   if (ws_reg[0] && wv[FLG_DONE] && !done_next) done_next = 1'b0;
        OFS_CURRENT, OFS_STATUS: ;
        default:     br_next = RESP_SLVERR;
      endcase
      if (awa_reg == OFS_FLAGS && ws_reg[0] && wv[FLG_DONE] && done_reg &&
          !(pending_reg && new_rdy_reg && !hold_reg && !sleep_i)) begin
        done_next = 1'b0;
      end
    end
    // Run requests: manual enables, current and requested source; manual enables only in sleep with no switch pending.
    run_next = {1'b0, man_en_reg} | src_run(cur_src_reg) | src_run(req_src_reg);
    if (sleep_i && !pending_reg) begin
      run_next = {1'b0, man_en_reg};
    end
    irq_next = done_reg && irq_en_reg && !sleep_i;
  end

  // Bus read path, registered answer one cycle after the address is taken.
  always_comb begin
    rv_next = rv_reg;
    rd_next = rd_reg;
    rr_next = rr_reg;
    if (rv_reg && s_axi_rready) begin
      rv_next = 1'b0;
    end
    if (s_axi_arvalid && !rv_reg) begin
      rv_next = 1'b1;
      rr_next = RESP_OKAY;
      rd_next = 32'h0000_0000;
      unique case (s_axi_araddr)
        OFS_CONTROL: rd_next = 32'({irq_en_reg, hold_reg, 1'b0, req_src_reg, req_div_reg});
        OFS_CURRENT: rd_next = 32'({1'b0, cur_src_reg, cur_div_reg});
        OFS_STATUS:  rd_next = 32'(status_w);
        OFS_ENABLE:  rd_next = 32'(man_en_reg);
        OFS_HF_FREQ: rd_next = 32'(hf_freq_reg);
        OFS_FLAGS:   rd_next = 32'({complete_reg, new_rdy_reg, done_reg});
        default:     rr_next = RESP_SLVERR;
      endcase
    end
  end

  // State registers.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      awv_reg <= 1'b0; wv_reg <= 1'b0; awa_reg <= '0; wd_reg <= 32'h0000_0000;
      ws_reg <= 4'h0; bv_reg <= 1'b0; br_reg <= RESP_OKAY;
      rv_reg <= 1'b0; rd_reg <= 32'h0000_0000; rr_reg <= RESP_OKAY;
      req_src_reg <= SRC_RESET; req_div_reg <= DIV_RESET;
      cur_src_reg <= SRC_RESET; cur_div_reg <= DIV_RESET;
      hold_reg <= 1'b0; irq_en_reg <= 1'b0; done_reg <= 1'b0;
      new_rdy_reg <= 1'b0; complete_reg <= 1'b1; pending_reg <= 1'b0;
      man_en_reg <= 6'h00; hf_freq_reg <= HF_FREQ_RST; hf_relock_reg <= 1'b0;
      run_reg <= 7'h00; irq_reg <= 1'b0;
    end else begin
      awv_reg <= awv_next; wv_reg <= wv_next; awa_reg <= awa_next; wd_reg <= wd_next;
      ws_reg <= ws_next; bv_reg <= bv_next; br_reg <= br_next;
      rv_reg <= rv_next; rd_reg <= rd_next; rr_reg <= rr_next;
      req_src_reg <= req_src_next; req_div_reg <= req_div_next;
      cur_src_reg <= cur_src_next; cur_div_reg <= cur_div_next;
      hold_reg <= hold_next; irq_en_reg <= irq_en_next; done_reg <= done_next;
      new_rdy_reg <= new_rdy_next; complete_reg <= complete_next;
      pending_reg <= pending_next; man_en_reg <= man_en_next;
      hf_freq_reg <= hf_freq_next; hf_relock_reg <= hf_relock_next;
      run_reg <= run_next; irq_reg <= irq_next;
    end
  end

  // Outputs straight from flip-flops.
  assign s_axi_awready         = !awv_reg;
  assign s_axi_wready          = !wv_reg;
  assign s_axi_bvalid          = bv_reg;
  assign s_axi_bresp           = br_reg;
  assign s_axi_arready         = !rv_reg;
  assign s_axi_rvalid          = rv_reg;
  assign s_axi_rdata           = rd_reg;
  assign s_axi_rresp           = rr_reg;
  assign osc_run_o             = run_reg;
  assign hf_output_hold_o      = hf_relock_reg;
  assign hf_frequency_select_o = hf_freq_reg;
  assign current_source_o      = cur_src_reg;
  assign current_divider_o     = cur_div_reg;
  assign irq_o                 = irq_reg;

endmodule // system_clock_switch_status

/* tb/clk_switch_asserts.sv */
/* Checker for the clock switch block; assumes it is bound to the top module ports. */
`timescale 1ns/10ps
module clk_switch_asserts (
  input wire logic       clk_i,             // Clock.
  input wire logic       rstn_i,            // Reset.
  input wire logic       s_axi_arvalid,     // Read request.
  input wire logic       s_axi_arready,     // Read ready.
  input wire logic       s_axi_rvalid,      // Read answer.
  input wire logic       s_axi_rready,      // Read taken.
  input wire logic       s_axi_bvalid,      // Write answer.
  input wire logic       s_axi_bready,      // Write taken.
  input wire logic       sleep_i,           // Sleep level.
  input wire logic       irq_o,             // Interrupt.
  input wire logic [2:0] current_source_o,  // Source.
  input wire logic [3:0] current_divider_o  // Divider.
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Sleep seen at two edges in a row.
  sequence s_asleep;
    sleep_i ##1 sleep_i;
  endsequence
  // Bus answers stand until taken; a read is answered the next cycle, and no new read is taken while answering.
  chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  chk_rresp_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  // Only legal selections ever reach the active fields.
  chk_src_legal: assert property (
    current_source_o inside {3'b111, 3'b110, 3'b101, 3'b100, 3'b010})
    else $error("reserved source active");
  chk_div_legal: assert property (current_divider_o <= 4'h9)
    else $error("reserved divider active");
  // Sleep blocks the interrupt and the switch.
  chk_sleep_irq: assert property (s_asleep |-> !irq_o)
    else $error("interrupt raised in sleep");
  chk_sleep_freeze: assert property (
    s_asleep |=> $stable(current_source_o) && $stable(current_divider_o))
    else $error("switch done in sleep");
endmodule // clk_switch_asserts
bind system_clock_switch_status clk_switch_asserts chk (.clk_i, .rstn_i, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .sleep_i,
  .irq_o, .current_source_o, .current_divider_o);

/* tb/system_clock_switch_status_tb.sv */
/* Testbench for the clock switch block; drives AXI4-Lite and oscillator levels itself. */
`timescale 1ns/10ps
module system_clock_switch_status_tb;
  import clk_switch_pkg::*;
  logic        clk_i = 1'b0, rstn_i = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, permit = 1'b0, sleep = 1'b0, lock = 1'b0;
  logic        awrdy, wrdy, bvalid, arrdy, rvalid, hf_hold, irq, tick;
  logic [1:0]  bresp, rresp;
  logic [2:0]  cur_src;
  logic [3:0]  cur_div, hf_sel, ecnt = 4'h0;
  logic [4:0]  acc = 5'h1F;
  logic [6:0]  run;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  int          bad_count = 0, checks_done = 0;
  system_clock_switch_status #(.STARTUP(8)) dut (.clk_i, .rstn_i, .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awrdy), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arrdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .switch_permit_config_i(permit), .sleep_i(sleep), .doze_i(1'b0),
    .ext_osc_clk_i(ecnt[1]), .sec_osc_clk_i(1'b0), .int_accurate_i(acc),
    .multiplier_lock_i(lock), .osc_run_o(run), .hf_output_hold_o(hf_hold),
    .hf_frequency_select_o(hf_sel), .current_source_o(cur_src), .current_divider_o(cur_div),
    .sys_tick_o(tick), .irq_o(irq));
  // System clock, and an external oscillator at a quarter of its rate.
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) ecnt <= ecnt + 4'h1;
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // Bus write; each channel is released at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awrdy) awvalid <= 1'b0;
      if (wrdy) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arrdy) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    rready <= 1'b0;
  endtask
  function automatic logic [31:0] ctl(input logic [2:0] s, input logic [3:0] d, input logic h,
                                      input logic e);
    return {22'h0, e, h, 1'b0, s, d};
  endfunction
  task automatic cur(input logic [31:0] e);
    rd(OFS_CURRENT);
    chk("current", v, e);
  endtask
  task automatic wait_done();
    for (int i = 0; i < 40; i++) begin
      rd(OFS_FLAGS);
      if (v[FLG_COMPLETE]) break;
    end
    chk("complete", {31'h0, v[FLG_COMPLETE]}, 32'h1);
  endtask
  task automatic t_refuse();
    logic [2:0] rs [3] = '{3'b000, 3'b001, 3'b011};
    cur(32'h60);
    wr(OFS_CONTROL, ctl(SRC_LOW, 4'h0, 1'b0, 1'b0));
    repeat (10) @(posedge clk_i);
    cur(32'h60);
    permit <= 1'b1;
    foreach (rs[i]) wr(OFS_CONTROL, ctl(rs[i], 4'h0, 1'b0, 1'b0));
    wr(OFS_CONTROL, ctl(SRC_HF, 4'hA, 1'b0, 1'b0));
    repeat (10) @(posedge clk_i);
    cur(32'h60);
    wr(8'h20, 32'h0);
    chk("bresp", {30'h0, bresp}, {30'h0, RESP_SLVERR});
    rd(8'h20);
    chk("rresp", {30'h0, rresp}, {30'h0, RESP_SLVERR});
  endtask
  task automatic t_divider();
    wr(OFS_CONTROL, ctl(SRC_HF, 4'h9, 1'b0, 1'b1));
    wait_done();
    cur(32'h69);
    rd(OFS_FLAGS);
    chk("flags", v, 32'h5);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(OFS_FLAGS, 32'h1);
    rd(OFS_FLAGS);
    chk("flags", v, 32'h4);
  endtask
  task automatic t_hold();
    wr(OFS_CONTROL, ctl(SRC_LOW, 4'h0, 1'b1, 1'b0));
    repeat (10) @(posedge clk_i);
    rd(OFS_FLAGS);
    chk("held", {30'h0, v[2:1]}, 32'h1);
    cur(32'h69);
    wr(OFS_CONTROL, ctl(SRC_LOW, 4'h0, 1'b0, 1'b0));
    wait_done();
    cur(32'h50);
    wr(OFS_CONTROL, ctl(SRC_SEC, 4'h0, 1'b1, 1'b0));
    repeat (10) @(posedge clk_i);
    rd(OFS_STATUS);
    chk("sec ready", {31'h0, v[OSC_SEC]}, 32'h0);
    wr(OFS_CONTROL, ctl(SRC_LOW, 4'h0, 1'b1, 1'b0));
    cur(32'h50);
  endtask
  task automatic t_pll();
    int n;
    wr(OFS_CONTROL, ctl(SRC_EXT_PLL, 4'h1, 1'b0, 1'b0));
    rd(OFS_STATUS);
    chk("ext early", {31'h0, v[OSC_EXT]}, 32'h0);
    repeat (60) @(posedge clk_i);
    rd(OFS_STATUS);
    chk("ext ready", {31'h0, v[OSC_EXT]}, 32'h1);
    cur(32'h50);
    lock <= 1'b1;
    wait_done();
    cur(32'h21);
    chk("cur out", {25'h0, cur_src, cur_div}, 32'h21);
    // Divide by two: one tick on every second edge.
    n = 0;
    repeat (8) begin
      @(posedge clk_i);
      n += tick;
    end
    chk("ticks", n, 32'h4);
  endtask
  task automatic t_sleep();
    wr(OFS_FLAGS, 32'h1);
    sleep <= 1'b1;
    wr(OFS_CONTROL, ctl(SRC_HF, 4'h0, 1'b0, 1'b0));
    repeat (20) @(posedge clk_i);
    cur(32'h21);
    sleep <= 1'b0;
    wait_done();
    chk("done", {31'h0, v[FLG_DONE]}, 32'h1);
    cur(32'h60);
    // Held request across sleep: new-ready drops, then returns on wake.
    wr(OFS_CONTROL, ctl(SRC_LOW, 4'h0, 1'b1, 1'b0));
    sleep <= 1'b1;
    repeat (10) @(posedge clk_i);
    rd(OFS_FLAGS);
    chk("sleep held", {31'h0, v[FLG_NEW_RDY]}, 32'h0);
    sleep <= 1'b0;
    repeat (10) @(posedge clk_i);
    rd(OFS_FLAGS);
    chk("wake held", {31'h0, v[FLG_NEW_RDY]}, 32'h1);
    cur(32'h60);
    wr(OFS_CONTROL, ctl(SRC_HF, 4'h0, 1'b0, 1'b0));
  endtask
  task automatic t_osc();
    acc[0] <= 1'b0;
    wr(OFS_HF_FREQ, 32'h5);
    chk("hf hold", {31'h0, hf_hold}, 32'h1);
    chk("hf select", {28'h0, hf_sel}, 32'h5);
    rd(OFS_STATUS);
    chk("hf ready", {31'h0, v[OSC_HF]}, 32'h0);
    acc[0] <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("hf hold", {31'h0, hf_hold}, 32'h0);
    rd(OFS_STATUS);
    chk("hf ready", {31'h0, v[OSC_HF]}, 32'h1);
    wr(OFS_ENABLE, 32'hFF);
    rd(OFS_ENABLE);
    chk("enable", v, 32'h3F);
    chk("run", {25'h0, run}, 32'h3F);
  endtask
  task automatic give_verdict();
    $display("mismatches %0d checks %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Reset for five cycles, then the scenarios in order.
  initial begin
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_refuse();
    t_divider();
    t_hold();
    t_pll();
    t_sleep();
    t_osc();
    give_verdict();
  end
  // Watchdog well beyond the expected run time.
  initial begin
    #100us;
    bad_count++;
    give_verdict();
  end
endmodule // system_clock_switch_status_tb
